// >>> hdl/scrs_top.sv
// Purpose: reset-cause flags, main and ADC clock selection and division
// Assumes: Avalon-MM slave, byte addresses, source clocks sampled on mclk
// Notes:   reset here only initialises this slice; causes come in as levels
module scrs_top (
    input  wire logic        mclk,              // 100 MHz clock
    input  wire logic        reset,             // synchronous, active high
    input  wire logic [31:0] avs_address,       // byte address
    input  wire logic        avs_read,          // read request
    input  wire logic        avs_write,         // write request
    input  wire logic [31:0] avs_writedata,     // write data
    input  wire logic [3:0]  avs_byteenable,    // byte lanes
    output logic [31:0]      avs_readdata,      // read data
    output logic             avs_waitrequest,   // high until answered
    input  wire logic        por_active,        // power-on/brownout reset
    input  wire logic        pin_reset_active,  // external pin reset
    input  wire logic        watchdog_reset,    // watchdog reset request
    input  wire logic        software_reset,    // software system reset
    input  wire logic        fast_osc_clk,      // internal fast oscillator
    input  wire logic        ext_clk,           // external clock
    input  wire logic        lowpower_osc_clk,  // low-power oscillator
    input  wire logic        scaled_osc_clk,    // scaled fast oscillator
    output logic             main_clock,        // selected main clock
    output logic             system_clock,      // divided system clock
    output logic             adc_clock          // divided ADC clock
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [4:0]  reset_cause_flags_r;
    logic [1:0]  main_source_select_r;
    logic        apply_bit_r;
    logic [1:0]  main_applied_r;
    logic [7:0]  system_clock_divider_r;
    logic [1:0]  adc_source_select_r;
    logic [7:0]  adc_clock_divider_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        req;
    logic        wr_go;
    logic        lane0;
    logic [4:0]  flag_set;
    logic [4:0]  flag_clr;
    logic [31:0] rdata_nxt;
    logic [3:0]  main_src;
    logic [3:0]  adc_src;
    logic        adc_mux;

    assign req   = avs_read || avs_write;
    assign wr_go = avs_write && !wait_r;
    assign lane0 = avs_byteenable[0];

    // ------------------------------------------------------------
    // bus handshake: answer one cycle after the request appears
    // ------------------------------------------------------------
    // writes act at the edge where waitrequest is seen low
    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !(req && wait_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address)
            scrs_pkg::ADDR_RESET_CAUSE: rdata_nxt[4:0] = reset_cause_flags_r;
            scrs_pkg::ADDR_MAIN_SEL:    rdata_nxt[1:0] = main_source_select_r;
            scrs_pkg::ADDR_MAIN_UPD:    rdata_nxt[0]   = apply_bit_r;
            scrs_pkg::ADDR_SYS_DIV:     rdata_nxt[7:0] = system_clock_divider_r;
            scrs_pkg::ADDR_ADC_SEL:     rdata_nxt[1:0] = adc_source_select_r;
            scrs_pkg::ADDR_ADC_DIV:     rdata_nxt[7:0] = adc_clock_divider_r;
            default:                    rdata_nxt      = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // reset-cause flags
    // ------------------------------------------------------------
    // active sources set their flag every cycle, so a source that
    // outlasts power-on reset is caught on the first free cycle
    always_comb begin
        flag_set                    = 5'h00;
        flag_set[scrs_pkg::BIT_POR] = por_active;
        flag_set[scrs_pkg::BIT_PIN] = pin_reset_active;
        flag_set[scrs_pkg::BIT_WDT] = watchdog_reset;
        flag_set[scrs_pkg::BIT_SW]  = software_reset;
        flag_clr = 5'h00;
        if (wr_go && lane0 && avs_address == scrs_pkg::ADDR_RESET_CAUSE) begin
            flag_clr = avs_writedata[4:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            reset_cause_flags_r <= scrs_pkg::FLAGS_RESET;
        end else if (por_active) begin
            reset_cause_flags_r <= scrs_pkg::FLAGS_AFTER_POR;
        end else begin
            reset_cause_flags_r <= ((reset_cause_flags_r & ~flag_clr) | flag_set)
                                   & scrs_pkg::FLAGS_VALID;
        end
    end

    // ------------------------------------------------------------
    // main source selection with update handshake
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            main_source_select_r <= scrs_pkg::MAIN_SEL_RESET;
        end else if (wr_go && lane0 && avs_address == scrs_pkg::ADDR_MAIN_SEL) begin
            main_source_select_r <= avs_writedata[1:0];
        end
    end

    // the applied source moves only on a 0-to-1 of the update bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            apply_bit_r    <= 1'b0;
            main_applied_r <= scrs_pkg::MAIN_SEL_RESET;
        end else if (wr_go && lane0 && avs_address == scrs_pkg::ADDR_MAIN_UPD) begin
            apply_bit_r <= avs_writedata[0];
            if (avs_writedata[0] && !apply_bit_r) begin
                main_applied_r <= main_source_select_r;
            end
        end
    end

    // ------------------------------------------------------------
    // divider and ADC selection registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            system_clock_divider_r <= scrs_pkg::SYS_DIV_RESET;
        end else if (wr_go && lane0 && avs_address == scrs_pkg::ADDR_SYS_DIV) begin
            system_clock_divider_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            adc_source_select_r <= scrs_pkg::ADC_SEL_RESET;
            adc_clock_divider_r <= scrs_pkg::ADC_DIV_RESET;
        end else if (wr_go && lane0) begin
            if (avs_address == scrs_pkg::ADDR_ADC_SEL) begin
                adc_source_select_r <= avs_writedata[1:0];
            end
            if (avs_address == scrs_pkg::ADDR_ADC_DIV) begin
                adc_clock_divider_r <= avs_writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // clock datapath
    // ------------------------------------------------------------
    // ADC codes 2 and 3 map to a source that never toggles
    assign main_src = {scaled_osc_clk, lowpower_osc_clk, ext_clk, fast_osc_clk};
    assign adc_src  = {2'b00, ext_clk, fast_osc_clk};

    scrs_glitch_mux u_main_mux (
        .mclk  (mclk),
        .reset (reset),
        .src   (main_src),
        .sel   (main_applied_r),
        .out_r (main_clock)
    );

    // one divided clock feeds core, memories and peripherals alike
    scrs_clk_div #(.RESET_RATIO(scrs_pkg::SYS_DIV_RESET)) u_sys_div (
        .mclk  (mclk),
        .reset (reset),
        .src   (main_clock),
        .ratio (system_clock_divider_r),
        .out_r (system_clock)
    );

    scrs_glitch_mux u_adc_mux (
        .mclk  (mclk),
        .reset (reset),
        .src   (adc_src),
        .sel   (adc_source_select_r),
        .out_r (adc_mux)
    );

    scrs_clk_div #(.RESET_RATIO(scrs_pkg::ADC_DIV_RESET)) u_adc_div (
        .mclk  (mclk),
        .reset (reset),
        .src   (adc_mux),
        .ratio (adc_clock_divider_r),
        .out_r (adc_clock)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    localparam int BITP = scrs_pkg::BIT_PIN;

    a_flag_w1c_clear: assert property (
        !por_active && !pin_reset_active && wr_go && lane0
        && avs_address == scrs_pkg::ADDR_RESET_CAUSE && avs_writedata[BITP]
        |=> !reset_cause_flags_r[BITP])
        else $error("pin flag not cleared by write one");

    a_flag_hold_zero: assert property (
        reset_cause_flags_r[scrs_pkg::BIT_WDT] && !por_active
        && !(wr_go && avs_writedata[scrs_pkg::BIT_WDT])
        |=> reset_cause_flags_r[scrs_pkg::BIT_WDT])
        else $error("watchdog flag lost without a clear");

    a_por_clears_all: assert property (
        por_active |=> reset_cause_flags_r == scrs_pkg::FLAGS_AFTER_POR)
        else $error("power-on did not clear other flags");

    a_por_release_pin: assert property (
        $fell(por_active) && pin_reset_active
        |-> reset_cause_flags_r[scrs_pkg::BIT_PIN] == 1'b0 ##1
            reset_cause_flags_r[scrs_pkg::BIT_PIN])
        else $error("pin reset outlasting power-on not flagged");

    a_por_bit_cause: assert property (
        $rose(reset_cause_flags_r[scrs_pkg::BIT_POR]) |-> $past(por_active))
        else $error("power-on flag set without power-on");

    a_reserved_zero: assert property (
        !wait_r |-> avs_readdata[31:8] == 24'h000000
        && !(avs_readdata[3] && $past(avs_address) == scrs_pkg::ADDR_RESET_CAUSE))
        else $error("reserved bits read nonzero");

    a_apply_edge: assert property (
        wr_go && lane0 && avs_address == scrs_pkg::ADDR_MAIN_UPD
        && avs_writedata[0] && !apply_bit_r
        |=> main_applied_r == $past(main_source_select_r))
        else $error("update edge did not apply source");

    a_apply_hold: assert property (
        !(wr_go && avs_address == scrs_pkg::ADDR_MAIN_UPD && avs_writedata[0]
          && !apply_bit_r) |=> $stable(main_applied_r))
        else $error("main source changed without update edge");

    a_bus_answer: assert property (
        req && wait_r |=> !wait_r ##1 wait_r)
        else $error("waitrequest not answered in one cycle");

    // ------------------------------------------------------------
    // register write checks
    // ------------------------------------------------------------
    // a lost write would leave a divider or selector on a stale value
    a_sys_div_write: assert property (
        wr_go && lane0 && avs_address == scrs_pkg::ADDR_SYS_DIV
        |=> system_clock_divider_r == $past(avs_writedata[7:0]))
        else $error("system divider write lost");

    a_adc_sel_write: assert property (
        wr_go && lane0 && avs_address == scrs_pkg::ADDR_ADC_SEL
        |=> adc_source_select_r == $past(avs_writedata[1:0]))
        else $error("adc source write lost");

    a_adc_div_write: assert property (
        wr_go && lane0 && avs_address == scrs_pkg::ADDR_ADC_DIV
        |=> adc_clock_divider_r == $past(avs_writedata[7:0]))
        else $error("adc divider write lost");

    c_main_switch: cover property (
        $changed(main_applied_r) ##[1:40] $changed(main_clock));
    c_por_pin: cover property ($fell(por_active) && pin_reset_active);
    c_flag_clear: cover property ($fell(reset_cause_flags_r[scrs_pkg::BIT_SW]));
    c_sys_stopped: cover property (system_clock_divider_r == 8'h00 ##8 !system_clock);
    c_adc_none: cover property (adc_source_select_r[1] && adc_clock_divider_r != 8'h00);
endmodule

// >>> hdl/scrs_pkg.sv
// Purpose: constants for the reset-cause and clock-source control slice
// Assumes: byte addresses on the register bus, 32-bit data
// Notes:   every field of this slice sits in byte lane 0
package scrs_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_RESET_CAUSE = 32'h4004_8038;
    localparam logic [31:0] ADDR_MAIN_SEL    = 32'h4004_8050;
    localparam logic [31:0] ADDR_MAIN_UPD    = 32'h4004_8054;
    localparam logic [31:0] ADDR_SYS_DIV     = 32'h4004_8058;
    localparam logic [31:0] ADDR_ADC_SEL     = 32'h4004_8064;
    localparam logic [31:0] ADDR_ADC_DIV     = 32'h4004_8068;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_POR          = 0;
    localparam int          BIT_PIN          = 1;
    localparam int          BIT_WDT          = 2;
    localparam int          BIT_SW           = 4;
    localparam logic [4:0]  FLAGS_VALID      = 5'h17; // bit 3 reserved
    localparam logic [4:0]  FLAGS_RESET      = 5'h00;
    localparam logic [4:0]  FLAGS_AFTER_POR  = 5'h01;
    localparam logic [1:0]  MAIN_SEL_RESET   = 2'h0;
    localparam logic [1:0]  ADC_SEL_RESET    = 2'h0;
    localparam logic [7:0]  SYS_DIV_RESET    = 8'h01;
    localparam logic [7:0]  ADC_DIV_RESET    = 8'h00;

    // ------------------------------------------------------------
    // source codes
    // ------------------------------------------------------------
    localparam logic [1:0]  SRC_FAST_OSC     = 2'h0;
    localparam logic [1:0]  SRC_EXT_CLK      = 2'h1;
    localparam logic [1:0]  SRC_LOWPWR_OSC   = 2'h2;
    localparam logic [1:0]  SRC_SCALED_OSC   = 2'h3;

    typedef enum logic {MUX_RUN, MUX_PARK} scrs_mux_e;
endpackage

// >>> hdl/scrs_glitch_mux.sv
// Purpose: glitch-free four-way selector for sampled clock waveforms
// Assumes: sources are levels sampled on mclk
// Notes:   leaves the old source while it is low, joins the new one while that is low
module scrs_glitch_mux (
    input  wire logic       mclk,   // system clock
    input  wire logic       reset,  // synchronous, active high
    input  wire logic [3:0] src,    // source levels
    input  wire logic [1:0] sel,    // requested source
    output logic            out_r   // selected clock level
);
    scrs_pkg::scrs_mux_e state_r;
    logic [1:0]          cur_r;

    // ------------------------------------------------------------
    // park low on the old source, resume on a low new source
    // ------------------------------------------------------------
    // parking avoids a short high pulse stitched from two clocks
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= scrs_pkg::MUX_RUN;
            cur_r   <= scrs_pkg::SRC_FAST_OSC;
            out_r   <= 1'b0;
        end else begin
            unique case (state_r)
                scrs_pkg::MUX_RUN: begin
                    out_r <= src[cur_r];
                    if (sel != cur_r && !src[cur_r]) begin
                        state_r <= scrs_pkg::MUX_PARK;
                        out_r   <= 1'b0;
                    end
                end
                scrs_pkg::MUX_PARK: begin
                    out_r <= 1'b0;
                    if (!src[sel]) begin
                        cur_r   <= sel;
                        state_r <= scrs_pkg::MUX_RUN;
                    end
                end
            endcase
        end
    end

    a_mux_park_low: assert property (@(posedge mclk) disable iff (reset)
        state_r == scrs_pkg::MUX_PARK |=> !out_r)
        else $error("mux output high while parked");
endmodule

// >>> hdl/scrs_clk_div.sv
// Purpose: 8-bit divider of a sampled clock waveform, zero stops it
// Assumes: source is a level sampled on mclk
// Notes:   new ratio adopted only at a period boundary
module scrs_clk_div #(
    parameter logic [7:0] RESET_RATIO = 8'h01  // ratio after reset
) (
    input  wire logic       mclk,   // system clock
    input  wire logic       reset,  // synchronous, active high
    input  wire logic       src,    // source level
    input  wire logic [7:0] ratio,  // requested divide ratio
    output logic            out_r   // divided clock level
);
    logic       prev_r;
    logic [7:0] cnt_r;
    logic [7:0] act_r;
    logic       rise;
    logic [8:0] cnt_inc;
    logic [8:0] half;

    assign rise    = src && !prev_r;
    assign cnt_inc = {1'b0, cnt_r} + 9'h001;
    assign half    = ({1'b0, act_r} + 9'h001) >> 1;

    // ------------------------------------------------------------
    // period counter; high for the first half of each period
    // ------------------------------------------------------------
    // ratio changes wait for a source rise that ends a period
    always_ff @(posedge mclk) begin
        if (reset) begin
            prev_r <= 1'b0;
            cnt_r  <= 8'h00;
            act_r  <= RESET_RATIO;
            out_r  <= 1'b0;
        end else begin
            prev_r <= src;
            if (rise) begin
                if (act_r <= 8'h01 || cnt_inc >= {1'b0, act_r}) begin
                    cnt_r <= 8'h00;
                    act_r <= ratio;
                    out_r <= (ratio != 8'h00);
                end else begin
                    cnt_r <= cnt_inc[7:0];
                    out_r <= (cnt_inc < half);
                end
            end else if (act_r == 8'h01) begin
                out_r <= src; // divide by one follows the source
            end
        end
    end

    a_div_zero_low: assert property (@(posedge mclk) disable iff (reset)
        act_r == 8'h00 && !rise |=> !out_r)
        else $error("divider output high with zero ratio");
endmodule

// >>> testbench/scrs_top_tb.sv
// Purpose: self-checking bench for the reset-cause and clock-source slice
// Assumes: sources are made from mclk counters, so periods are whole mclk cycles
// Notes:   periods are measured between the third and fourth rise to skip switch-over
module scrs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and design signals
    // ------------------------------------------------------------
    logic        mclk             = 1'b0;
    logic        reset            = 1'b1;
    logic [31:0] avs_address      = 32'h0;
    logic        avs_read         = 1'b0;
    logic        avs_write        = 1'b0;
    logic [31:0] avs_writedata    = 32'h0;
    logic [3:0]  avs_byteenable   = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        por_active       = 1'b0;
    logic        pin_reset_active = 1'b0;
    logic        watchdog_reset   = 1'b0;
    logic        software_reset   = 1'b0;
    logic [4:0]  src_cnt          = 5'h00;
    logic        main_clock;
    logic        system_clock;
    logic        adc_clock;
    int          fail_count       = 0;
    int          total_checks     = 0;
    int          p;
    int          prev_p;
    int          main_per [4]     = '{4, 8, 32, 16};
    logic [7:0]  sdiv [5]         = '{8'h03, 8'h02, 8'hff, 8'h01, 8'h00};
    int          sper [5]         = '{12, 8, 1020, 4, 0};
    logic [1:0]  asel [6]         = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [7:0]  adiv [6]         = '{8'h02, 8'h02, 8'h01, 8'h02, 8'h02, 8'h00};
    int          aper [6]         = '{8, 16, 8, 0, 0, 0};

    // clock and source waveforms; all sources slower than half of mclk
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        src_cnt <= src_cnt + 5'h01;
    end

    scrs_top i_dut (
        .mclk             (mclk),
        .reset            (reset),
        .avs_address      (avs_address),
        .avs_read         (avs_read),
        .avs_write        (avs_write),
        .avs_writedata    (avs_writedata),
        .avs_byteenable   (avs_byteenable),
        .avs_readdata     (avs_readdata),
        .avs_waitrequest  (avs_waitrequest),
        .por_active       (por_active),
        .pin_reset_active (pin_reset_active),
        .watchdog_reset   (watchdog_reset),
        .software_reset   (software_reset),
        .fast_osc_clk     (src_cnt[1]),
        .ext_clk          (src_cnt[2]),
        .lowpower_osc_clk (src_cnt[4]),
        .scaled_osc_clk   (src_cnt[3]),
        .main_clock       (main_clock),
        .system_clock     (system_clock),
        .adc_clock        (adc_clock)
    );

    // ------------------------------------------------------------
    // bus tasks and comparisons
    // ------------------------------------------------------------
    // request starts one edge after the previous release, so no signal is set twice
    task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] q);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        // no local limit: only the watchdog ends a wait
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, 4'hf, q);
    endtask

    task automatic check_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic read_check(input string what, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, 4'hf, q);
        check_reg(what, e, q);
    endtask

    task automatic check_period(input string what, input int e, input int g);
        total_checks++;
        if (g != e) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", what, e, g);
        end
    endtask

    // period in mclk cycles, 0 when the clock shows no four rises in the window and rests low
    task automatic measure(input int w, output int per);
        int   n;
        int   r;
        int   t3;
        logic prev;
        logic cur;
        logic bad;
        per  = 0;
        bad  = 1'b0;
        r    = 0;
        t3   = 0;
        prev = 1'b1;
        for (n = 0; n < 5000 && r < 4; n++) begin
            @(posedge mclk);
            cur = (w == 0) ? main_clock : ((w == 1) ? system_clock : adc_clock);
            if (cur === 1'b1 && prev !== 1'b1) begin
                r++;
                if (r == 3) t3 = n;
                if (r == 4) per = n - t3;
            end
            if (cur !== 1'b0 && cur !== 1'b1) bad = 1'b1;
            prev = cur;
        end
        // a stopped clock must rest low and never show an unknown
        if (bad || (r < 4 && cur !== 1'b0)) per = -1;
    endtask

    task automatic set_cause(input int b);
        @(posedge mclk);
        pin_reset_active <= (b == 1);
        watchdog_reset   <= (b == 2);
        software_reset   <= (b == 4);
        @(posedge mclk);
        pin_reset_active <= 1'b0;
        watchdog_reset   <= 1'b0;
        software_reset   <= 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        read_check("flags", scrs_pkg::ADDR_RESET_CAUSE, 32'h0);
        read_check("main sel", scrs_pkg::ADDR_MAIN_SEL, 32'h0);
        read_check("update", scrs_pkg::ADDR_MAIN_UPD, 32'h0);
        read_check("sys div", scrs_pkg::ADDR_SYS_DIV, 32'h1);
        read_check("adc sel", scrs_pkg::ADDR_ADC_SEL, 32'h0);
        read_check("adc div", scrs_pkg::ADDR_ADC_DIV, 32'h0);
        read_check("unmapped", 32'h4004_803c, 32'h0);
        $display("test reset_values finished");
        set_cause(1);
        read_check("pin flag", scrs_pkg::ADDR_RESET_CAUSE, 32'h2);
        set_cause(2);
        read_check("wdt flag", scrs_pkg::ADDR_RESET_CAUSE, 32'h6);
        set_cause(4);
        read_check("sw flag", scrs_pkg::ADDR_RESET_CAUSE, 32'h16);
        bus_write(scrs_pkg::ADDR_RESET_CAUSE, 32'h0);
        read_check("zero write", scrs_pkg::ADDR_RESET_CAUSE, 32'h16);
        bus_write(scrs_pkg::ADDR_RESET_CAUSE, 32'hffff_ffea);
        read_check("one clear", scrs_pkg::ADDR_RESET_CAUSE, 32'h14);
        // pin held across power-on release must be caught afterwards
        @(posedge mclk);
        por_active       <= 1'b1;
        pin_reset_active <= 1'b1;
        read_check("por only", scrs_pkg::ADDR_RESET_CAUSE, 32'h1);
        por_active <= 1'b0;
        repeat (2) @(posedge mclk);
        pin_reset_active <= 1'b0;
        read_check("pin after por", scrs_pkg::ADDR_RESET_CAUSE, 32'h3);
        bus_write(scrs_pkg::ADDR_RESET_CAUSE, 32'h1f);
        read_check("all clear", scrs_pkg::ADDR_RESET_CAUSE, 32'h0);
        $display("test cause_flags finished");
        bus_write(scrs_pkg::ADDR_MAIN_SEL, 32'hffff_ffff);
        read_check("sel reserved", scrs_pkg::ADDR_MAIN_SEL, 32'h3);
        bus_write(scrs_pkg::ADDR_MAIN_SEL, 32'h0);
        bus_write(scrs_pkg::ADDR_MAIN_UPD, 32'h1);
        prev_p = 4;
        foreach (main_per[k]) begin
            bus_write(scrs_pkg::ADDR_MAIN_SEL, 32'((k + 1) % 4));
            bus_write(scrs_pkg::ADDR_MAIN_UPD, 32'h1);
            measure(0, p);
            check_period("main after repeat one", prev_p, p);
            bus_write(scrs_pkg::ADDR_MAIN_UPD, 32'h0);
            measure(0, p);
            check_period("main after zero", prev_p, p);
            bus_write(scrs_pkg::ADDR_MAIN_UPD, 32'h1);
            measure(0, p);
            prev_p = main_per[(k + 1) % 4];
            check_period("main after toggle", prev_p, p);
        end
        $display("test main_select finished");
        foreach (sdiv[k]) begin
            bus_write(scrs_pkg::ADDR_SYS_DIV, {24'hffff_ff, sdiv[k]});
            read_check("sys div", scrs_pkg::ADDR_SYS_DIV, {24'h0, sdiv[k]});
            measure(1, p);
            check_period("system clock", sper[k], p);
        end
        $display("test system_divider finished");
        foreach (asel[k]) begin
            bus_write(scrs_pkg::ADDR_ADC_SEL, {30'h0, asel[k]});
            bus_write(scrs_pkg::ADDR_ADC_DIV, {24'h0, adiv[k]});
            measure(2, p);
            check_period("adc clock", aper[k], p);
        end
        $display("test adc_clock finished");
        test_done();
    end

    // watchdog: the tests need about 27000 cycles
    initial begin
        repeat (90000) @(posedge mclk);
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
endmodule
